//--- cbp_top.sv
// Common bus pin block: AXI4-Lite register front end, interrupt and test sampling
//
// Notes on behaviour
// R1 - Low sixteen lines carry address in first state, data in later states.
// R2 - High four lines carry address in first state, status afterwards.
// R3 - Two status bits encode segment: extra, stack, code or none, data.
// R4 - Fifth status bit shows the interrupt enable flag.
// R5 - Sixth status bit is always zero during status.
// R6 - Shared pin gives upper byte enable first, a status bit afterwards.
// R7 - Upper byte enable with address bit zero selects byte lanes.
// R8 - Word: both low; upper byte: enable low, bit one; lower: enable high.
// R9 - Read strobe low times reads, high otherwise.
// R10 - Ready low holds the transfer; ready high lets it finish.
// R11 - Wait states sit between third and fourth state while ready low.
// R12 - Maskable request level sampled only in an instruction's last cycle.
// R13 - Maskable request ignored while interrupt enable flag is clear.
// R14 - An outside controller may supply up to 256 vector types; this block has no vector input.
// R15 - Wait instruction idles while test input high, resumes when low.
`timescale 1ns/100ps
module cbp_top
	import cbp_pkg::*;
#(
	parameter int AXI_AW = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// AXI4-Lite write address and data
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Bus pins
	input wire logic [15:0] muxed_addr_data_i,
	output logic [15:0] muxed_addr_data_o,
	output logic muxed_addr_data_oe,
	output logic [3:0] high_addr_status,
	output logic upper_byte_enable_n,
	output logic rd_n,
	input wire logic ready,
	// Interrupt and test pins
	input wire logic maskable_irq_req,
	input wire logic test_in
);
	// Register decode looks at the low eight address bits, so narrower buses cannot be served
	if (AXI_AW < 8 || AXI_AW > 32) begin
		$error("AXI_AW must be 8 to 32");
	end

	cbp_cyc_if cyc();

	logic [AXI_AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic do_write;
	logic wr_hit;
	logic [31:0] ctrl_new, addr_new, wdata_new, status_new, flags_new, insn_new;
	logic ctrl_wr, ctrl_word;
	logic [1:0] ctrl_seg;
	logic [19:0] addr_reg;
	logic [15:0] wdata_reg;
	logic ie_flag;
	logic go;
	logic done_flag, align_flag, irq_pend, test_wait;
	logic insn_end, wait_cmd;
	logic irq_s1, irq_s2, test_s1, test_s2;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_reg(input logic [AXI_AW-1:0] a, input logic [7:0] off);
		return a[7:0] == off && (AXI_AW == 8 || a >> 8 == '0);
	endfunction

	function automatic logic mapped(input logic [AXI_AW-1:0] a);
		return is_reg(a, CBP_OFF_CTRL) || is_reg(a, CBP_OFF_ADDR) || is_reg(a, CBP_OFF_WDATA)
			|| is_reg(a, CBP_OFF_RDATA) || is_reg(a, CBP_OFF_STATUS)
			|| is_reg(a, CBP_OFF_FLAGS) || is_reg(a, CBP_OFF_INSN);
	endfunction

	// Write channel: address and data taken in either order, one write at a time
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_hit = mapped(wr_addr);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CBP_RESP_OKAY;
			wr_addr <= '0;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? CBP_RESP_OKAY : CBP_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_comb begin
		ctrl_new = merge({26'h0, ctrl_seg, 1'b0, ctrl_word, ctrl_wr, 1'b0}, wr_data, wr_strb);
		addr_new = merge({12'h000, addr_reg}, wr_data, wr_strb);
		wdata_new = merge({16'h0000, wdata_reg}, wr_data, wr_strb);
		status_new = merge(32'h00000000, wr_data, wr_strb);
		flags_new = merge({31'h0, ie_flag}, wr_data, wr_strb);
		insn_new = merge(32'h00000000, wr_data, wr_strb);
	end

	// Bus cycle set-up registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_wr <= 1'b0;
			ctrl_word <= 1'b0;
			ctrl_seg <= CBP_RST_SEG;
			addr_reg <= CBP_RST_ADDR;
			wdata_reg <= CBP_RST_DATA;
		end else if (do_write) begin
			if (is_reg(wr_addr, CBP_OFF_CTRL)) begin
				ctrl_wr <= ctrl_new[CBP_CTRL_WR];
				ctrl_word <= ctrl_new[CBP_CTRL_WORD];
				ctrl_seg <= ctrl_new[CBP_CTRL_SEG_HI:CBP_CTRL_SEG_LO];
			end
			if (is_reg(wr_addr, CBP_OFF_ADDR)) begin
				addr_reg <= addr_new[19:0];
			end
			if (is_reg(wr_addr, CBP_OFF_WDATA)) begin
				wdata_reg <= wdata_new[15:0];
			end
		end
	end

	// Start pulse; a start while busy is dropped, an odd word address is flagged
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			go <= 1'b0;
			align_flag <= 1'b0;
		end else begin
			go <= do_write && is_reg(wr_addr, CBP_OFF_CTRL) && ctrl_new[CBP_CTRL_GO]
				&& !cyc.busy && !go && !(ctrl_new[CBP_CTRL_WORD] && addr_reg[0]);
			// R8 - odd word refused
			if (do_write && is_reg(wr_addr, CBP_OFF_CTRL) && ctrl_new[CBP_CTRL_GO]
				&& ctrl_new[CBP_CTRL_WORD] && addr_reg[0]) begin
				align_flag <= 1'b1;
			end else if (do_write && is_reg(wr_addr, CBP_OFF_STATUS)
				&& status_new[CBP_ST_ALIGN]) begin
				align_flag <= 1'b0;
			end
		end
	end

	always_comb begin
		cyc.req = go;
		cyc.wr = ctrl_wr;
		cyc.word = ctrl_word;
		cyc.addr = addr_reg;
		cyc.wdata = wdata_reg;
		cyc.seg = ctrl_seg;
		cyc.ie = ie_flag;
	end

	// Completion flag, set wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			done_flag <= 1'b0;
		end else if (cyc.done) begin
			done_flag <= 1'b1;
		end else if (do_write && is_reg(wr_addr, CBP_OFF_STATUS) && status_new[CBP_ST_DONE]) begin
			done_flag <= 1'b0;
		end
	end

	// Interrupt enable flag and instruction strobes
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ie_flag <= CBP_RST_IE;
			insn_end <= 1'b0;
			wait_cmd <= 1'b0;
		end else begin
			if (do_write && is_reg(wr_addr, CBP_OFF_FLAGS)) begin
				ie_flag <= flags_new[CBP_FL_IE];
			end
			insn_end <= do_write && is_reg(wr_addr, CBP_OFF_INSN) && insn_new[CBP_IN_END];
			wait_cmd <= do_write && is_reg(wr_addr, CBP_OFF_INSN) && insn_new[CBP_IN_WAIT];
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_s1 <= 1'b0;
			irq_s2 <= 1'b0;
			test_s1 <= 1'b0;
			test_s2 <= 1'b0;
		end else begin
			irq_s1 <= maskable_irq_req;
			irq_s2 <= irq_s1;
			test_s1 <= test_in;
			test_s2 <= test_s1;
		end
	end

	// R12 - R13 - sample request at instruction end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			irq_pend <= 1'b0;
		end else if (insn_end && ie_flag && irq_s2) begin
			irq_pend <= 1'b1;
		end else if (do_write && is_reg(wr_addr, CBP_OFF_STATUS) && status_new[CBP_ST_IRQ]) begin
			irq_pend <= 1'b0;
		end
	end

	// R15 - idle while test high
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			test_wait <= 1'b0;
		end else if (wait_cmd) begin
			test_wait <= 1'b1;
		end else if (test_wait && !test_s2) begin
			test_wait <= 1'b0;
		end
	end

	// Read channel, answer one cycle after the address is taken
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= CBP_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr) ? CBP_RESP_OKAY : CBP_RESP_SLVERR;
				s_axi_rdata <= 32'h00000000;
				if (is_reg(s_axi_araddr, CBP_OFF_CTRL)) begin
					s_axi_rdata <= {26'h0, ctrl_seg, 1'b0, ctrl_word, ctrl_wr, 1'b0};
				end else if (is_reg(s_axi_araddr, CBP_OFF_ADDR)) begin
					s_axi_rdata <= {12'h000, addr_reg};
				end else if (is_reg(s_axi_araddr, CBP_OFF_WDATA)) begin
					s_axi_rdata <= {16'h0000, wdata_reg};
				end else if (is_reg(s_axi_araddr, CBP_OFF_RDATA)) begin
					s_axi_rdata <= {16'h0000, cyc.rdata};
				end else if (is_reg(s_axi_araddr, CBP_OFF_STATUS)) begin
					s_axi_rdata <= {27'h0, test_wait, irq_pend, align_flag, done_flag,
						cyc.busy | go};
				end else if (is_reg(s_axi_araddr, CBP_OFF_FLAGS)) begin
					s_axi_rdata <= {31'h0, ie_flag};
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	cbp_cycle u_cycle (
		.mclk(mclk),
		.nrst(nrst),
		.cyc(cyc.eng),
		.muxed_addr_data_i(muxed_addr_data_i),
		.muxed_addr_data_o(muxed_addr_data_o),
		.muxed_addr_data_oe(muxed_addr_data_oe),
		.high_addr_status(high_addr_status),
		.upper_byte_enable_n(upper_byte_enable_n),
		.rd_n(rd_n),
		.ready(ready)
	);

	a_irq_sampled: assert property (@(posedge mclk) disable iff (!nrst) // R12 R13
		$rose(irq_pend) |-> $past(insn_end) && $past(ie_flag) && $past(irq_s2))
		else $error("interrupt taken outside instruction end or while masked");
	a_irq_masked: assert property (@(posedge mclk) disable iff (!nrst) // R13
		insn_end && !ie_flag && !irq_pend |=> !irq_pend)
		else $error("masked interrupt accepted");
	a_test_idle: assert property (@(posedge mclk) disable iff (!nrst) // R15
		test_wait && test_s2 |=> test_wait)
		else $error("wait ended while test high");
	a_test_resume: assert property (@(posedge mclk) disable iff (!nrst) // R15
		test_wait && !test_s2 && !wait_cmd |=> !test_wait)
		else $error("wait not ended on test low");
endmodule

//--- cbp_pkg.sv
// Shared constants and types for the common bus pin block
package cbp_pkg;
	// Register byte offsets
	localparam logic [7:0] CBP_OFF_CTRL = 8'h00;
	localparam logic [7:0] CBP_OFF_ADDR = 8'h04;
	localparam logic [7:0] CBP_OFF_WDATA = 8'h08;
	localparam logic [7:0] CBP_OFF_RDATA = 8'h0C;
	localparam logic [7:0] CBP_OFF_STATUS = 8'h10;
	localparam logic [7:0] CBP_OFF_FLAGS = 8'h14;
	localparam logic [7:0] CBP_OFF_INSN = 8'h18;
	// Control field positions
	localparam int CBP_CTRL_GO = 0;
	localparam int CBP_CTRL_WR = 1;
	localparam int CBP_CTRL_WORD = 2;
	localparam int CBP_CTRL_SEG_LO = 4;
	localparam int CBP_CTRL_SEG_HI = 5;
	// Status field positions
	localparam int CBP_ST_BUSY = 0;
	localparam int CBP_ST_DONE = 1;
	localparam int CBP_ST_ALIGN = 2;
	localparam int CBP_ST_IRQ = 3;
	localparam int CBP_ST_TESTW = 4;
	// Flag and instruction field positions
	localparam int CBP_FL_IE = 0;
	localparam int CBP_IN_END = 0;
	localparam int CBP_IN_WAIT = 1;
	// Values after reset
	localparam logic [19:0] CBP_RST_ADDR = 20'h00000;
	localparam logic [15:0] CBP_RST_DATA = 16'h0000;
	localparam logic [1:0] CBP_RST_SEG = 2'h0;
	localparam logic CBP_RST_IE = 1'b0;
	// Value carried on the shared upper-byte pin in the bus states after the first
	localparam logic CBP_SHARED_STATUS = 1'b0;
	// Segment codes on the two segment status bits
	localparam logic [1:0] CBP_SEG_EXTRA = 2'h0;
	localparam logic [1:0] CBP_SEG_STACK = 2'h1;
	localparam logic [1:0] CBP_SEG_CODE = 2'h2;
	localparam logic [1:0] CBP_SEG_DATA = 2'h3;
	// AXI responses
	localparam logic [1:0] CBP_RESP_OKAY = 2'h0;
	localparam logic [1:0] CBP_RESP_SLVERR = 2'h2;
	// Bus states, Gray coded along idle, first, second, third, fourth
	typedef enum logic [2:0] {
		CBP_IDLE = 3'h0,
		CBP_T1 = 3'h1,
		CBP_T2 = 3'h3,
		CBP_T3 = 3'h2,
		CBP_T4 = 3'h6,
		CBP_TW = 3'h7
	} cbp_state_t;
endpackage

//--- cbp_cyc_if.sv
// Request and answer signals between register front end and bus cycle engine
`timescale 1ns/100ps
interface cbp_cyc_if;
	logic req;
	logic wr;
	logic word;
	logic [19:0] addr;
	logic [15:0] wdata;
	logic [1:0] seg;
	logic ie;
	logic busy;
	logic done;
	logic [15:0] rdata;
	modport ctl(output req, wr, word, addr, wdata, seg, ie, input busy, done, rdata);
	modport eng(input req, wr, word, addr, wdata, seg, ie, output busy, done, rdata);
endinterface

//--- cbp_cycle.sv
// Bus cycle engine driving the multiplexed pins through T1..T4 with waits
`timescale 1ns/100ps
module cbp_cycle
	import cbp_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Request side
	cbp_cyc_if.eng cyc,
	// Pins
	input wire logic [15:0] muxed_addr_data_i,
	output logic [15:0] muxed_addr_data_o,
	output logic muxed_addr_data_oe,
	output logic [3:0] high_addr_status,
	output logic upper_byte_enable_n,
	output logic rd_n,
	input wire logic ready
);
	cbp_state_t st, next_st;
	logic rdy_s1, rdy_s2;
	logic [15:0] ad_s1, ad_s2;
	logic lat_wr, lat_word;
	logic [19:0] lat_addr;
	logic [15:0] lat_wdata;
	logic [1:0] lat_seg;
	logic cur_wr, cur_word;
	logic [19:0] cur_addr;
	logic [15:0] cur_wdata;
	logic [1:0] cur_seg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdy_s1 <= 1'b0;
			rdy_s2 <= 1'b0;
			ad_s1 <= CBP_RST_DATA;
			ad_s2 <= CBP_RST_DATA;
		end else begin
			rdy_s1 <= ready;
			rdy_s2 <= rdy_s1;
			ad_s1 <= muxed_addr_data_i;
			ad_s2 <= ad_s1;
		end
	end

	always_comb begin
		next_st = st;
		case (st)
			CBP_IDLE: begin
				if (cyc.req) begin
					next_st = CBP_T1;
				end
			end
			CBP_T1: next_st = CBP_T2;
			CBP_T2: next_st = CBP_T3;
			// R11 - wait while not ready
			CBP_T3, CBP_TW: begin
				next_st = rdy_s2 ? CBP_T4 : CBP_TW;
			end
			CBP_T4: next_st = CBP_IDLE;
			default: next_st = CBP_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st <= CBP_IDLE;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lat_wr <= 1'b0;
			lat_word <= 1'b0;
			lat_addr <= CBP_RST_ADDR;
			lat_wdata <= CBP_RST_DATA;
			lat_seg <= CBP_RST_SEG;
		end else if (st == CBP_IDLE && cyc.req) begin
			lat_wr <= cyc.wr;
			lat_word <= cyc.word;
			lat_addr <= cyc.addr;
			lat_wdata <= cyc.wdata;
			lat_seg <= cyc.seg;
		end
	end

	// Pins are registered from the next state, so the request is used live on entry
	always_comb begin
		cur_wr = (st == CBP_IDLE) ? cyc.wr : lat_wr;
		cur_word = (st == CBP_IDLE) ? cyc.word : lat_word;
		cur_addr = (st == CBP_IDLE) ? cyc.addr : lat_addr;
		cur_wdata = (st == CBP_IDLE) ? cyc.wdata : lat_wdata;
		cur_seg = (st == CBP_IDLE) ? cyc.seg : lat_seg;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			muxed_addr_data_o <= CBP_RST_DATA;
			muxed_addr_data_oe <= 1'b0;
			high_addr_status <= 4'h0;
			upper_byte_enable_n <= 1'b1;
			rd_n <= 1'b1;
		end else begin
			case (next_st)
				// R1 - address phase
				CBP_T1: begin
					muxed_addr_data_o <= cur_addr[15:0];
					muxed_addr_data_oe <= 1'b1;
					// R2 - high address bits
					high_addr_status <= cur_addr[19:16];
					// R7 - R8 - byte lane code
					upper_byte_enable_n <= ~(cur_word | cur_addr[0]);
					rd_n <= 1'b1;
				end
				CBP_T2, CBP_T3, CBP_TW, CBP_T4: begin
					muxed_addr_data_o <= cur_wr ? cur_wdata : CBP_RST_DATA;
					muxed_addr_data_oe <= cur_wr;
					// R3 - R4 - R5 - status nibble
					high_addr_status <= {1'b0, cyc.ie, cur_seg};
					// R6 - shared status bit
					upper_byte_enable_n <= CBP_SHARED_STATUS;
					// R9 - read strobe
					rd_n <= cur_wr;
				end
				default: begin
					muxed_addr_data_o <= CBP_RST_DATA;
					muxed_addr_data_oe <= 1'b0;
					high_addr_status <= 4'h0;
					upper_byte_enable_n <= 1'b1;
					rd_n <= 1'b1;
				end
			endcase
		end
	end

	// R10 - finish once ready seen
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cyc.done <= 1'b0;
			cyc.rdata <= CBP_RST_DATA;
		end else begin
			cyc.done <= (st == CBP_T4);
			if (st == CBP_T4 && !lat_wr) begin
				cyc.rdata <= ad_s2;
			end
		end
	end

	assign cyc.busy = (st != CBP_IDLE);

	sequence s_start;
		st == CBP_IDLE && cyc.req;
	endsequence
	sequence s_ready_seen;
		(st == CBP_T3 || st == CBP_TW) && rdy_s2;
	endsequence
	sequence s_data_states;
		st == CBP_T2 || st == CBP_T3 || st == CBP_TW || st == CBP_T4;
	endsequence

	a_cycle_order: assert property (@(posedge mclk) disable iff (!nrst) // R1
		s_start |=> st == CBP_T1 ##1 st == CBP_T2 ##1 st == CBP_T3)
		else $error("bus states out of order");
	a_addr_phase: assert property (@(posedge mclk) disable iff (!nrst) // R1 R2
		st == CBP_T1 |-> muxed_addr_data_oe && muxed_addr_data_o == lat_addr[15:0]
			&& high_addr_status == lat_addr[19:16])
		else $error("address not driven in first state");
	a_status_nibble: assert property (@(posedge mclk) disable iff (!nrst) // R3 R4 R5
		s_data_states |-> high_addr_status == {1'b0, $past(cyc.ie), lat_seg})
		else $error("status nibble wrong");
	a_byte_lanes: assert property (@(posedge mclk) disable iff (!nrst) // R7 R8
		st == CBP_T1 |-> upper_byte_enable_n == !(lat_word || lat_addr[0])
			&& muxed_addr_data_o[0] == lat_addr[0])
		else $error("byte lane code wrong");
	a_shared_pin: assert property (@(posedge mclk) disable iff (!nrst) // R6
		s_data_states |-> upper_byte_enable_n == CBP_SHARED_STATUS)
		else $error("shared status bit wrong");
	a_read_strobe: assert property (@(posedge mclk) disable iff (!nrst) // R9
		s_data_states |-> rd_n == lat_wr && muxed_addr_data_oe == lat_wr)
		else $error("read strobe wrong");
	a_idle_strobe: assert property (@(posedge mclk) disable iff (!nrst) // R9
		st == CBP_IDLE || st == CBP_T1 |-> rd_n)
		else $error("read strobe low outside data states");
	a_wait_ready: assert property (@(posedge mclk) disable iff (!nrst) // R11
		(st == CBP_T3 || st == CBP_TW) && !rdy_s2 |=> st == CBP_TW)
		else $error("no wait state while not ready");
	a_ready_end: assert property (@(posedge mclk) disable iff (!nrst) // R10
		s_ready_seen |=> st == CBP_T4 ##1 (st == CBP_IDLE && cyc.done))
		else $error("cycle did not end after ready");
endmodule

//--- cbp_mem_model.sv
// Memory and I/O partner answering multiplexed bus cycles
`timescale 1ns/100ps
module cbp_mem_model (
	// Clock
	input wire logic mclk,
	// Pins from the block
	input wire logic [15:0] muxed_addr_data_o,
	input wire logic muxed_addr_data_oe,
	input wire logic [3:0] high_addr_status,
	input wire logic upper_byte_enable_n,
	input wire logic rd_n,
	// Pins to the block
	output logic [15:0] muxed_addr_data_i,
	output logic ready,
	// Bench control
	input wire logic [3:0] wait_cycles
);
	logic [15:0] mem [256];
	logic [19:0] a;
	logic [15:0] wd, held;
	logic [3:0] cnt;
	logic b, oe_q, st, wr, t1;
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 16'hC000 + 16'(i);
		{oe_q, st, wr, cnt, held} = '0;
	end
	// First state is the first cycle with the pins driven after idle
	assign t1 = muxed_addr_data_oe && !oe_q;
	always @(posedge mclk) begin
		oe_q <= muxed_addr_data_oe;
		if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
		if (t1) begin
			a <= {high_addr_status, muxed_addr_data_o};
			b <= upper_byte_enable_n;
			st <= 1'b1;
			cnt <= wait_cycles;
		end else if (st && muxed_addr_data_oe) begin
			wd <= muxed_addr_data_o;
			wr <= 1'b1;
		end else if (st) begin
			st <= 1'b0;
			wr <= 1'b0;
			if (wr && !a[0])
				mem[a[8:1]][7:0] <= wd[7:0];
			if (wr && !b)
				mem[a[8:1]][15:8] <= wd[15:8];
		end
		if (!rd_n)
			held <= mem[a[8:1]];
	end
	// vector types come from an outside controller; this partner supplies none
	// ready held low; dropped already in the first state so the sync chain sees it
	assign ready = (cnt == 4'h0) && !(t1 && wait_cycles != 4'h0);
	// Released bus shows the inverse of the last word, never a stale copy
	assign muxed_addr_data_i = !rd_n ? mem[a[8:1]] : ~held;
endmodule

//--- cpu_bus_common_pins_test.sv
// Self-checking bench for the common bus pin block
`timescale 1ns/100ps
module cpu_bus_common_pins_test
	import cbp_pkg::*;
;
	logic mclk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0] s_axi_wstrb, high_addr_status, wait_cycles;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [15:0] muxed_addr_data_i, muxed_addr_data_o;
	logic muxed_addr_data_oe, upper_byte_enable_n, rd_n, ready, maskable_irq_req, test_in;
	int num_errors, cmp_count;
	cbp_top DUT (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .muxed_addr_data_i, .muxed_addr_data_o, .muxed_addr_data_oe,
		.high_addr_status, .upper_byte_enable_n, .rd_n, .ready, .maskable_irq_req, .test_in);
	cbp_mem_model MEM (.mclk, .muxed_addr_data_o, .muxed_addr_data_oe, .high_addr_status,
		.upper_byte_enable_n, .rd_n, .muxed_addr_data_i, .ready, .wait_cycles);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 60) begin
			num_errors++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		tmo(n);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 60; n++) begin
			@(posedge mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		tmo(n);
		rv = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// One bus cycle, judged at the pins state by state
	task automatic cyc(input logic [19:0] a, input logic [15:0] d, input logic word,
		input logic [1:0] s, input logic w, input logic ie);
		int n, len;
		wr(CBP_OFF_ADDR, 32'(a));
		wr(CBP_OFF_WDATA, 32'(d));
		wr(CBP_OFF_CTRL, {26'h0, s, 1'b0, word, w, 1'b1});
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (!muxed_addr_data_oe && n < 60);
		tmo(n);
		chk({high_addr_status, muxed_addr_data_o}, a);
		chk(upper_byte_enable_n, !word && !a[0]);
		@(posedge mclk);
		chk(high_addr_status, {1'b0, ie, s});
		chk(upper_byte_enable_n, CBP_SHARED_STATUS);
		chk(rd_n, w);
		if (w)
			chk(muxed_addr_data_o, d);
		for (len = 1; len < 60; len++) begin
			@(posedge mclk);
			if (!(w ? muxed_addr_data_oe : !rd_n))
				break;
			chk(high_addr_status[3], 1'b0);
		end
		tmo(len);
		if (wait_cycles == 4'h0)
			chk(len, 3);
		else
			chk(len > 3, 1'b1);
		rd(CBP_OFF_STATUS);
		chk(rv[CBP_ST_DONE], 1'b1);
		wr(CBP_OFF_STATUS, 32'h2);
	endtask
	task automatic t_reset();
		chk({muxed_addr_data_oe, upper_byte_enable_n, rd_n, high_addr_status}, 7'h30);
		rd(CBP_OFF_STATUS);
		chk(rv, 32'h0);
		rd(8'h1C);
		chk(rs, CBP_RESP_SLVERR);
		chk(rv, 32'h0);
		wr(8'h1C, 32'hFFFF);
		chk(rs, CBP_RESP_SLVERR);
		wr(CBP_OFF_RDATA, 32'hFFFF);
		rd(CBP_OFF_RDATA);
		chk(rs, CBP_RESP_OKAY);
		chk(rv, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_wcyc();
		logic [19:0] a;
		logic [15:0] d, old, ex;
		logic word, ube;
		for (int i = 0; i < 4; i++) begin
			word = (i == 0 || i == 3);
			a = {4'(4 * i + 3), 16'h0040 + 16'(4 * i) + 16'(i == 2)};
			d = word ? 16'hBEEF - 16'(i) : 16'h3C3C + 16'h0101 * 16'(i);
			ube = !word && !a[0];
			old = MEM.mem[a[8:1]];
			wr(CBP_OFF_FLAGS, 32'(i[0]));
			cyc(a, d, word, 2'(i), 1'b1, i[0]);
			ex = {ube ? old[15:8] : d[15:8], a[0] ? old[7:0] : d[7:0]};
			chk(MEM.mem[a[8:1]], ex);
		end
		$display("write cycle test done");
	endtask
	task automatic t_rcyc();
		logic [19:0] a;
		wr(CBP_OFF_FLAGS, 32'h1);
		for (int i = 0; i < 2; i++) begin
			wait_cycles <= 4'(5 * i);
			a = {4'h9, 16'h0080 + 16'(4 * i)};
			cyc(a, 16'h0, 1'b1, CBP_SEG_CODE, 1'b0, 1'b1);
			rd(CBP_OFF_RDATA);
			chk(rv, {16'h0, MEM.mem[a[8:1]]});
		end
		wait_cycles <= 4'h0;
		$display("read cycle test done");
	endtask
	task automatic t_odd();
		wr(CBP_OFF_ADDR, 32'h41);
		wr(CBP_OFF_CTRL, 32'h5);
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk);
			chk(muxed_addr_data_oe, 1'b0);
		end
		rd(CBP_OFF_STATUS);
		chk(rv[CBP_ST_ALIGN], 1'b1);
		wr(CBP_OFF_STATUS, 32'h4);
		$display("odd word test done");
	endtask
	task automatic t_irq();
		maskable_irq_req <= 1'b1;
		wr(CBP_OFF_FLAGS, 32'h0);
		wr(CBP_OFF_INSN, 32'h1);
		rd(CBP_OFF_STATUS);
		chk(rv[CBP_ST_IRQ], 1'b0);
		wr(CBP_OFF_FLAGS, 32'h1);
		rd(CBP_OFF_STATUS);
		chk(rv[CBP_ST_IRQ], 1'b0);
		wr(CBP_OFF_INSN, 32'h1);
		rd(CBP_OFF_STATUS);
		chk(rv[CBP_ST_IRQ], 1'b1);
		maskable_irq_req <= 1'b0;
		wr(CBP_OFF_STATUS, 32'h8);
		wr(CBP_OFF_INSN, 32'h1);
		rd(CBP_OFF_STATUS);
		chk(rv[CBP_ST_IRQ], 1'b0);
		$display("interrupt test done");
	endtask
	task automatic t_test();
		int n;
		test_in <= 1'b1;
		wr(CBP_OFF_INSN, 32'h2);
		rd(CBP_OFF_STATUS);
		rd(CBP_OFF_STATUS);
		chk(rv[CBP_ST_TESTW], 1'b1);
		test_in <= 1'b0;
		for (n = 0; n < 8 && rv[CBP_ST_TESTW]; n++)
			rd(CBP_OFF_STATUS);
		chk(rv[CBP_ST_TESTW], 1'b0);
		$display("test input test done");
	endtask
	initial begin
		{nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, wait_cycles} = '0;
		{maskable_irq_req, test_in} = '0;
		s_axi_wstrb = 4'hF;
		{num_errors, cmp_count} = '0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		t_reset();
		t_wcyc();
		t_rcyc();
		t_odd();
		t_irq();
		t_test();
		end_of_test();
	end
endmodule
